// ==== rtl/eil_top.sv ====
// External interrupt latch, gating and status/control register.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
module eil_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq_pin_n,
  input wire logic [3:0] port_int_pins,
  input wire logic trig_level_option,
  input wire logic port_int_option,
  input wire logic cpu_int_mask,
  input wire logic vector_fetch,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic ext_int_request,
  output logic internal_lowpower_osc_en,
  output logic external_pin_osc_en,
  output logic cpu_clk_external
);

  // ----------------------------------------------------------------
  // Pin synchronizers
  // ----------------------------------------------------------------
  logic irq_pin_s;
  logic [3:0] port_pins_s;

  eil_sync #(
    .W(1),
    .RST_VAL(eil_pkg::IRQ_PIN_IDLE)
  ) u_sync_irq (
    .clk(clk),
    .rst(rst),
    .async_in(irq_pin_n),
    .sync_out(irq_pin_s)
  );

  eil_sync #(
    .W(eil_pkg::PORT_PINS),
    .RST_VAL(eil_pkg::PORT_PIN_IDLE)
  ) u_sync_port (
    .clk(clk),
    .rst(rst),
    .async_in(port_int_pins),
    .sync_out(port_pins_s)
  );

  // ----------------------------------------------------------------
  // Mask options
  // ----------------------------------------------------------------
  logic level_mode_q;
  logic port_opt_q;

  // The options are straps: they are sampled only while reset is high, so a
  // change during operation has no effect until the next reset.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      level_mode_q <= trig_level_option; // RL21 RL3
      port_opt_q <= port_int_option; // RL21
    end
  end

  // ----------------------------------------------------------------
  // Source combination
  // ----------------------------------------------------------------
  // Both pin kinds are merged into one active-high line before edge
  // detection. While one input holds the line active, a change on any
  // other input produces no edge, which is exactly the masking behaviour
  // between the dedicated pin and the port pins.
  logic irq_low_w;
  logic port_any_w;
  logic src_w;
  logic src_prev_q;
  logic rise_w;
  logic set_w;

  assign irq_low_w = ~irq_pin_s; // RL1
  assign port_any_w = port_opt_q & (|port_pins_s); // RL6 RL9
  assign src_w = irq_low_w | port_any_w; // RL9 RL10 RL16
  assign rise_w = src_w & ~src_prev_q; // RL20 RL1 RL8
  assign set_w = level_mode_q ? src_w : rise_w; // RL2 RL3 RL7

  always_ff @(posedge clk)
  begin
    if (rst)
      src_prev_q <= 1'b0;
    else
      src_prev_q <= src_w; // RL20
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic hit_w;
  logic wr_hit_w;
  logic rd_hit_w;
  logic sw_clear_w;
  logic clear_w;

  assign hit_w = (addr == eil_pkg::ISC_OFFSET);
  assign wr_hit_w = wr_en & hit_w;
  assign rd_hit_w = rd_en & hit_w;
  assign sw_clear_w = wr_hit_w & wr_data[eil_pkg::CLEAR_BIT]; // RL17 RL18
  assign clear_w = vector_fetch | sw_clear_w; // RL5 RL17

  // ----------------------------------------------------------------
  // Request latch and control bits
  // ----------------------------------------------------------------
  logic pending_q;
  logic pending_d;
  logic enable_q;
  logic osc_hi_q;
  logic osc_lo_q;

  // A new request in the clearing cycle wins, so it is never lost.
  assign pending_d = set_w ? 1'b1 : (clear_w ? 1'b0 : pending_q); // RL5 RL15 RL17

  always_ff @(posedge clk)
  begin
    if (rst)
      pending_q <= eil_pkg::PENDING_RST; // RL12 RL15
    else
      pending_q <= pending_d; // RL19
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enable_q <= eil_pkg::ENABLE_RST; // RL12
      osc_hi_q <= eil_pkg::OSC_HI_RST; // RL12
      osc_lo_q <= eil_pkg::OSC_LO_RST; // RL12
    end
    else if (wr_hit_w)
    begin
      enable_q <= wr_data[eil_pkg::ENABLE_BIT]; // RL13
      osc_hi_q <= wr_data[eil_pkg::OSC_HI_BIT]; // RL14
      osc_lo_q <= wr_data[eil_pkg::OSC_LO_BIT]; // RL14
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] read_val_w;
  logic [7:0] rd_data_d;

  // Only the defined fields are placed; everything else stays zero,
  // including the write-only clear position.
  always_comb
  begin
    read_val_w = 8'h00; // RL11 RL18
    read_val_w[eil_pkg::ENABLE_BIT] = enable_q;
    read_val_w[eil_pkg::OSC_HI_BIT] = osc_hi_q;
    read_val_w[eil_pkg::OSC_LO_BIT] = osc_lo_q;
    read_val_w[eil_pkg::PENDING_BIT] = pending_q; // RL15
  end

  assign rd_data_d = rd_hit_w ? read_val_w : 8'h00;

  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data <= 8'h00;
    else
      rd_data <= rd_data_d;
  end

  // ----------------------------------------------------------------
  // Request to the CPU and oscillator controls
  // ----------------------------------------------------------------
  logic req_d;
  logic int_osc_en_d;
  logic ext_osc_en_d;
  logic clk_ext_d;

  assign req_d = pending_q & ~cpu_int_mask & enable_q; // RL4 RL19 RL13
  assign int_osc_en_d = ~(osc_lo_q & ~osc_hi_q); // RL14
  assign ext_osc_en_d = osc_lo_q; // RL14
  assign clk_ext_d = osc_lo_q & ~osc_hi_q; // RL14

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_int_request <= 1'b0;
      internal_lowpower_osc_en <= 1'b1;
      external_pin_osc_en <= 1'b0;
      cpu_clk_external <= 1'b0;
    end
    else
    begin
      ext_int_request <= req_d; // RL4
      internal_lowpower_osc_en <= int_osc_en_d; // RL14
      external_pin_osc_en <= ext_osc_en_d; // RL14
      cpu_clk_external <= clk_ext_d; // RL14
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  edge_sets_latch_a: assert property ( // RL1
    (!level_mode_q && rise_w) |=> pending_q)
    else $error("edge on the merged source did not set the latch");

  level_holds_latch_a: assert property ( // RL2
    (level_mode_q && src_w) |=> pending_q [*1])
    else $error("active level did not keep the latch set");

  set_has_source_a: assert property ( // RL16
    $rose(pending_q) |-> $past(src_w))
    else $error("latch set without an active source");

  edge_no_rearm_a: assert property ( // RL8
    (!level_mode_q && src_prev_q && src_w && clear_w) |=> !pending_q)
    else $error("held source re-latched in edge mode");

  fetch_clears_latch_a: assert property ( // RL5
    (vector_fetch && !set_w) |=> !pending_q)
    else $error("vector fetch did not clear the latch");

  port_hidden_a: assert property ( // RL10
    (!level_mode_q && irq_low_w && $past(irq_low_w)) |-> !set_w)
    else $error("port pins not ignored while pin held low");

  request_gating_a: assert property ( // RL4
    (pending_q && !cpu_int_mask && enable_q) |=> ext_int_request)
    else $error("enabled pending request not signalled");

  masked_kept_a: assert property ( // RL19
    (pending_q && cpu_int_mask && !clear_w) |=> pending_q && !ext_int_request)
    else $error("masked request lost or signalled");

  reset_values_a: assert property ( // RL12
    $fell(rst) |-> (enable_q && osc_hi_q && !osc_lo_q && !pending_q))
    else $error("wrong register state after reset");

  unused_zero_a: assert property ( // RL11
    1'b1 |=> (rd_data & 8'h65) == 8'h00)
    else $error("unused or write-only bits read as one");

  flag_write_ignored_a: assert property ( // RL15
    (wr_hit_w && !wr_data[eil_pkg::CLEAR_BIT] && !vector_fetch && !set_w)
      |=> pending_q == $past(pending_q))
    else $error("write changed the pending flag");

  osc_decode_a: assert property ( // RL14
    ##1 internal_lowpower_osc_en == $past(!(osc_lo_q && !osc_hi_q)))
    else $error("oscillator enable decode wrong");

  read_returns_a: assert property ( // RL13
    rd_hit_w |=> rd_data[eil_pkg::ENABLE_BIT] == $past(enable_q))
    else $error("enable bit read back wrong");

  clear_only_a: assert property ( // RL17
    (sw_clear_w && !set_w) |=> !pending_q)
    else $error("software clear did not clear the latch");

  // Set beats clear, so a request that arrives during the vector fetch
  // is kept for the next service pass instead of being dropped.
  set_beats_clear_a: assert property ( // RL5
    (set_w && clear_w) |=> pending_q)
    else $error("new request lost in the clearing cycle");

  port_level_a: assert property ( // RL7
    (level_mode_q && port_any_w) |=> pending_q)
    else $error("high port pin did not keep the latch set");

  port_masks_pin_a: assert property ( // RL9
    (!level_mode_q && port_any_w && $past(port_any_w)) |-> !set_w)
    else $error("sources not ignored while a port pin is high");

  port_ignored_a: assert property ( // RL16
    (!port_opt_q && irq_pin_s) |=> !$rose(pending_q))
    else $error("port pins set the latch while disabled");

  mask_blocks_a: assert property ( // RL4
    (cpu_int_mask || !enable_q || !pending_q) |=> !ext_int_request)
    else $error("request signalled while masked, disabled or idle");

  enable_write_a: assert property ( // RL13
    wr_hit_w |=> enable_q == $past(wr_data[eil_pkg::ENABLE_BIT]))
    else $error("enable bit write did not land");

  osc_write_a: assert property ( // RL14
    wr_hit_w |=> {osc_hi_q, osc_lo_q} ==
      $past({wr_data[eil_pkg::OSC_HI_BIT], wr_data[eil_pkg::OSC_LO_BIT]}))
    else $error("oscillator select write did not land");

  pending_read_a: assert property ( // RL15
    rd_hit_w |=> rd_data[eil_pkg::PENDING_BIT] == $past(pending_q))
    else $error("pending flag read back wrong");

  osc_read_a: assert property ( // RL14
    rd_hit_w |=> rd_data[eil_pkg::OSC_HI_BIT] == $past(osc_hi_q)
      && rd_data[eil_pkg::OSC_LO_BIT] == $past(osc_lo_q))
    else $error("oscillator select read back wrong");

  idle_read_zero_a: assert property ( // RL11
    !rd_hit_w |=> rd_data == 8'h00)
    else $error("read data not zero outside a read");

  ext_osc_decode_a: assert property ( // RL14
    ##1 (external_pin_osc_en == $past(osc_lo_q) &&
      cpu_clk_external == $past(osc_lo_q && !osc_hi_q)))
    else $error("external oscillator decode wrong");

  // The pin checks skip the two edges after reset, while the stages still
  // hold their idle values instead of the pin history.
  irq_sync_a: assert property ( // RL20
    (!$past(rst) && !$past(rst, 2)) |-> irq_pin_s == $past(irq_pin_n, 2))
    else $error("interrupt pin synchronizer delay wrong");

  port_sync_a: assert property ( // RL20
    (!$past(rst) && !$past(rst, 2)) |-> port_pins_s == $past(port_int_pins, 2))
    else $error("port pin synchronizer delay wrong");

  reset_outputs_a: assert property ( // RL12
    $fell(rst) |-> (!ext_int_request && internal_lowpower_osc_en
      && !external_pin_osc_en && !cpu_clk_external && rd_data == 8'h00))
    else $error("wrong output state after reset");

  // The straps must not follow their inputs once reset is gone.
  options_held_a: assert property ( // RL21
    !$past(rst) |-> (level_mode_q == $past(level_mode_q)
      && port_opt_q == $past(port_opt_q)))
    else $error("mask option changed outside reset");

  // ----------------------------------------------------------------
  // Cover properties
  // ----------------------------------------------------------------
  port_edge_c: cover property (port_any_w && !src_prev_q ##1 pending_q);
  edge_latch_c: cover property (!level_mode_q && rise_w ##1 pending_q);
  level_hold_c: cover property (level_mode_q && src_w && vector_fetch ##1 pending_q);
  fetch_clear_c: cover property (pending_q && vector_fetch ##1 !pending_q);
  sw_clear_c: cover property (pending_q && sw_clear_w ##1 !pending_q);

endmodule

// ==== rtl/eil_pkg.sv ====
// Constants, register layout and reset values of the external interrupt logic.
// How it works
// RL1: Edge mode: falling pin edge sets latch.
// RL2: Level mode: low pin also sets latch.
// RL3: One option bit picks sensitivity everywhere.
// RL4: Request goes out when unmasked and enabled.
// RL5: Vector fetch clears the latch.
// RL6: Port option enables rising-edge port requests.
// RL7: Level mode: high port pin sets latch.
// RL8: Edge mode: port must fall, rise again.
// RL9: High port pin hides other sources.
// RL10: Low interrupt pin hides port pins.
// RL11: Unused register bits read zero.
// RL12: Reset sets enable and oscillator high bit.
// RL13: Enable bit is read/write.
// RL14: Oscillator select bits pick clock sources.
// RL15: Pending flag read-only, reset clears it.
// RL16: Pin or enabled port pins set flag.
// RL17: Vector fetch or clear bit clears flag.
// RL18: Clear bit write-only, reads zero.
// RL19: Masked request stays latched until unmasked.
// RL20: Pins pass two flops, edges by compare.
// RL21: Mask options sampled only during reset.
package eil_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ISC_OFFSET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions of the status and control register
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT = 7;
  localparam int OSC_HI_BIT = 4;
  localparam int OSC_LO_BIT = 3;
  localparam int PENDING_BIT = 1;
  localparam int CLEAR_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic ENABLE_RST = 1'b1;
  localparam logic OSC_HI_RST = 1'b1;
  localparam logic OSC_LO_RST = 1'b0;
  localparam logic PENDING_RST = 1'b0;
  localparam logic IRQ_PIN_IDLE = 1'b1;
  localparam logic [3:0] PORT_PIN_IDLE = 4'h0;
  localparam int PORT_PINS = 4;

endpackage

// ==== rtl/eil_sync.sv ====
// Two-stage synchronizer for a group of asynchronous pins.
`timescale 1ns/100ps
module eil_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1_q <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      stage1_q <= async_in; // RL20
      sync_out <= stage1_q; // RL20
    end
  end

endmodule

// ==== verif/eil_pin_src.sv ====
// Model of the interrupt sources that drive the pins.
`timescale 1ns/100ps
module eil_pin_src (
  input wire logic [1:0] irq_src,
  input wire logic [3:0] port_src,
  output logic irq_pin_n,
  output logic [3:0] port_int_pins
);
  // Two open-drain sources share the pin, so the pull-up wins only when both let go.
  assign irq_pin_n = ~|irq_src;
  assign port_int_pins = port_src;
endmodule

// ==== verif/eil_tb_top.sv ====
// Self-checking bench for the external interrupt logic.
`timescale 1ns/100ps
module eil_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] irq_src = 2'b00;
  logic [3:0] port_src = 4'h0;
  logic irq_pin_n;
  logic [3:0] port_int_pins;
  logic trig = 1'b0;
  logic popt = 1'b1;
  logic mask = 1'b0;
  logic vf = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rd_data;
  logic req;
  logic int_osc;
  logic ext_osc;
  logic cext;
  logic [7:0] rv;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  eil_pin_src eil_pin_src_i (.irq_src(irq_src), .port_src(port_src),
    .irq_pin_n(irq_pin_n), .port_int_pins(port_int_pins));

  eil_top eil_top_i (.clk(clk), .rst(rst), .irq_pin_n(irq_pin_n),
    .port_int_pins(port_int_pins), .trig_level_option(trig), .port_int_option(popt),
    .cpu_int_mask(mask), .vector_fetch(vf), .addr(addr), .wr_data(wd), .wr_en(wr),
    .rd_en(rd), .rd_data(rd_data), .ext_int_request(req), .internal_lowpower_osc_en(int_osc),
    .external_pin_osc_en(ext_osc), .cpu_clk_external(cext));

  // ----------------------------------------------------------------
  // Reporting and access tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Sampling lands just after the edge so registered outputs have settled.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rd_data;
  endtask

  task automatic chk(input logic [7:0] exp);
    rd_reg(8'h00);
    cmp8(rv, exp);
  endtask

  // Pins change after an edge, then get enough cycles to pass the synchronizer.
  task automatic pins(input logic [1:0] i, input logic [3:0] p);
    @(posedge clk);
    irq_src <= i;
    port_src <= p;
    step(4);
  endtask

  task automatic vfetch();
    @(posedge clk);
    vf <= 1'b1;
    @(posedge clk);
    vf <= 1'b0;
  endtask

  task automatic do_reset(input logic t, input logic p);
    @(posedge clk);
    rst <= 1'b1;
    trig <= t;
    popt <= p;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk(8'h90);
    cmp1(int_osc, 1'b1);
    cmp1(ext_osc, 1'b0);
    wr_reg(8'h00, 8'hFF);
    chk(8'h98);
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(8'h00, {1'b1, 2'b00, c[1], c[0], 3'b000});
      step(2);
      cmp1(int_osc, !(c[0] && !c[1]));
      cmp1(ext_osc, c[0]);
      cmp1(cext, c[0] && !c[1]);
    end
    wr_reg(8'h00, 8'h90);
    rd_reg(8'h01);
    cmp8(rv, 8'h00);
    wr_reg(8'h00, 8'h92);
    chk(8'h90);
    pins(2'b01, 4'h0);
    chk(8'h92);
    cmp1(req, 1'b1);
    @(posedge clk);
    mask <= 1'b1;
    step(2);
    cmp1(req, 1'b0);
    vfetch();
    step(4);
    chk(8'h90);
    pins(2'b00, 4'h0);
    pins(2'b01, 4'h0);
    chk(8'h92);
    cmp1(req, 1'b0);
    @(posedge clk);
    mask <= 1'b0;
    step(2);
    cmp1(req, 1'b1);
    wr_reg(8'h00, 8'h10);
    step(2);
    cmp1(req, 1'b0);
    wr_reg(8'h00, 8'h90);
    chk(8'h92);
    wr_reg(8'h00, 8'h91);
    chk(8'h90);
    pins(2'b00, 4'h0);
    pins(2'b00, 4'h4);
    chk(8'h92);
    wr_reg(8'h00, 8'h91);
    step(4);
    chk(8'h90);
    pins(2'b01, 4'h4);
    pins(2'b01, 4'h6);
    chk(8'h90);
    pins(2'b01, 4'h0);
    pins(2'b01, 4'h1);
    chk(8'h90);
    pins(2'b00, 4'h0);
    pins(2'b00, 4'h1);
    chk(8'h92);
    do_reset(1'b1, 1'b0);
    pins(2'b00, 4'hF);
    chk(8'h90);
    pins(2'b11, 4'h0);
    pins(2'b10, 4'h0);
    vfetch();
    chk(8'h92);
    wr_reg(8'h00, 8'h91);
    chk(8'h92);
    pins(2'b00, 4'h0);
    wr_reg(8'h00, 8'h91);
    chk(8'h90);
    do_reset(1'b1, 1'b1);
    pins(2'b00, 4'h8);
    vfetch();
    chk(8'h92);
    pins(2'b00, 4'h0);
    wr_reg(8'h00, 8'h91);
    chk(8'h90);
    final_report();
  end
endmodule
